//--- rtl/ssr_device.sv
`timescale 1ns/1ps
module ssr_device (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // Link to host
    ssr_link_if.dev         LINK,
    // User side
    output logic [7:0]      CONFIG,
    output logic            PROTECTED,
    output logic            RESET_BUSY,
    output logic            SAMPLE_TICK,
    output logic            SYNC_PULSE,
    output logic            SNAP_PULSE
);

    ////////////////////////////////////////////////////////////////////////
    localparam logic [11:0] PERIOD_LAST =
        12'(ssr_pkg::OUT_PERIOD_CYC - 1);
    localparam logic [7:0]  RESET_LOAD  =
        8'(ssr_pkg::RESET_BUSY_CYC);

    logic [7:0]  rst_cnt_q;
    logic        busy;
    logic        ack_q;
    logic [15:0] rdata_q;
    logic        take;
    logic        wr;
    logic        rd;
    logic [7:0]  cfg_q;
    logic [7:0]  chk_prev_q;
    logic        chk_flag_q;
    logic        prot_q;
    logic        align_q;
    logic        latch_q;
    logic [11:0] cnt_q;
    logic [11:0] snap_q;
    logic        tick_q;
    logic        seen_q;
    logic        unread_q;
    logic [15:0] rd_mux;

    // Folded checksum over the configuration byte
    function automatic logic [7:0] ssr_chk(input logic [7:0] v);
        ssr_chk = v ^ {v[3:0], v[7:4]} ^ 8'h5a;
    endfunction

    assign take = LINK.req && !ack_q;
    assign wr   = take && LINK.we && !busy;
    assign rd   = take && !LINK.we;
    assign busy = (rst_cnt_q != 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // Reset-in-progress countdown
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            rst_cnt_q <= RESET_LOAD;
        else if (busy)
            rst_cnt_q <= rst_cnt_q - 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Link handshake and read data
    always_comb
    begin
        rd_mux = 16'h0000;
        unique case (LINK.addr)
            ssr_pkg::ADDR_SNAPSHOT:
                rd_mux = {4'h0, snap_q};
            ssr_pkg::ADDR_CONFIG:
                rd_mux = {8'h00, cfg_q};
            ssr_pkg::ADDR_PSTATUS:
            begin
                rd_mux[ssr_pkg::PS_RESET_BIT] = busy;
                rd_mux[ssr_pkg::PS_CHK_BIT]   = chk_flag_q;
                rd_mux[ssr_pkg::PS_PROT_BIT]  = prot_q;
            end
            ssr_pkg::ADDR_KEY:
                rd_mux = 16'h0000;
            ssr_pkg::ADDR_STROBES:
                rd_mux = {14'h0000, latch_q, align_q};
            ssr_pkg::ADDR_SSTATUS:
            begin
                rd_mux[2:0] = ssr_pkg::REVISION;
                rd_mux[ssr_pkg::SS_UNREAD_BIT] = unread_q;
            end
            default:
                rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ack_q <= 1'b0;
        else
            ack_q <= take;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            rdata_q <= 16'h0000;
        else if (rd)
            rdata_q <= rd_mux;
        else if (take)
            rdata_q <= 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and protection
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            prot_q <= 1'b0;
        else if (wr && LINK.addr == ssr_pkg::ADDR_KEY)
        begin
            if (LINK.wdata == ssr_pkg::KEY_LOCK)
                prot_q <= 1'b1;
            else if (LINK.wdata == ssr_pkg::KEY_UNLOCK)
                prot_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            cfg_q <= ssr_pkg::CONFIG_RST;
        else if (wr && LINK.addr == ssr_pkg::ADDR_CONFIG && !prot_q)
            cfg_q <= LINK.wdata;
    end

    // Checksum watch; a change wins over a clearing read
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            chk_prev_q <= 8'h00;
            chk_flag_q <= 1'b0;
        end
        else
        begin
            chk_prev_q <= ssr_chk(cfg_q);
            if (busy)
                chk_flag_q <= 1'b0;
            else if (ssr_chk(cfg_q) != chk_prev_q)
                chk_flag_q <= 1'b1;
            else if (rd && LINK.addr == ssr_pkg::ADDR_PSTATUS)
                chk_flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alignment and latch strobes
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            align_q <= 1'b0;
            latch_q <= 1'b0;
        end
        else
        begin
            align_q <= wr && LINK.addr == ssr_pkg::ADDR_STROBES
                       && LINK.wdata[ssr_pkg::ST_ALIGN_BIT];
            latch_q <= wr && LINK.addr == ssr_pkg::ADDR_STROBES
                       && LINK.wdata[ssr_pkg::ST_LATCH_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output period counter
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cnt_q  <= 12'h000;
            tick_q <= 1'b0;
        end
        else if (align_q)
        begin
            cnt_q  <= 12'h000;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (cnt_q == PERIOD_LAST);
            cnt_q  <= (cnt_q == PERIOD_LAST) ? 12'h000 : cnt_q + 12'h001;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            snap_q <= 12'h000;
        else if (latch_q)
            snap_q <= cnt_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Unread-sample tracking; a new miss wins over a clearing read
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            seen_q <= 1'b0;
        else if (tick_q)
            seen_q <= 1'b0;
        else if (rd && LINK.addr <= ssr_pkg::ADDR_DATA_LAST)
            seen_q <= 1'b1;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            unread_q <= 1'b0;
        else if (tick_q && !seen_q
                 && !(rd && LINK.addr <= ssr_pkg::ADDR_DATA_LAST))
            unread_q <= 1'b1;
        else if (rd && LINK.addr == ssr_pkg::ADDR_SSTATUS)
            unread_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    assign LINK.ack    = ack_q;
    assign LINK.rdata  = rdata_q;
    assign CONFIG      = cfg_q;
    assign PROTECTED   = prot_q;
    assign RESET_BUSY  = busy;
    assign SAMPLE_TICK = tick_q;
    assign SYNC_PULSE  = align_q;
    assign SNAP_PULSE  = latch_q;

endmodule

//--- rtl/ssr_host.sv
`timescale 1ns/1ps
module ssr_host (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Interrupt
    output logic             IRQ,
    // Link to device
    ssr_link_if.host         LINK
);

    ////////////////////////////////////////////////////////////////////////
    ssr_pkg::ssr_host_state_e st_q;
    logic                     req_q;
    logic                     we_q;
    logic [7:0]               addr_q;
    logic [7:0]               wdata_q;
    logic [15:0]              res_q;
    logic [ssr_pkg::IRQ_W-1:0] istat_q;
    logic [ssr_pkg::IRQ_W-1:0] imask_q;
    logic [31:0]              prdata_q;
    logic                     apb_wr;
    logic                     mapped;
    logic                     go;
    logic                     done;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == ssr_pkg::H_CMD) || (a == ssr_pkg::H_RESULT)
                 || (a == ssr_pkg::H_ISTAT) || (a == ssr_pkg::H_IMASK);
    endfunction

    assign mapped  = is_mapped(PADDR);
    assign apb_wr  = PSEL && PENABLE && PWRITE && mapped;
    assign go      = apb_wr && PADDR == ssr_pkg::H_CMD
                     && PWDATA[ssr_pkg::CMD_GO_BIT];
    assign done    = (st_q == ssr_pkg::HS_WAIT) && LINK.ack;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA  = prdata_q;
    assign IRQ     = |(istat_q & imask_q);

    ////////////////////////////////////////////////////////////////////////
    // Link transfer sequencer
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            st_q <= ssr_pkg::HS_IDLE;
        else
            unique case (st_q)
                ssr_pkg::HS_IDLE:
                    if (go)
                        st_q <= ssr_pkg::HS_WAIT;
                ssr_pkg::HS_WAIT:
                    if (LINK.ack)
                        st_q <= ssr_pkg::HS_DONE;
                ssr_pkg::HS_DONE:
                    st_q <= ssr_pkg::HS_IDLE;
                default:
                    st_q <= ssr_pkg::HS_IDLE;
            endcase
    end

    // Request stays up until the device acknowledges it
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            req_q   <= 1'b0;
            we_q    <= 1'b0;
            addr_q  <= 8'h00;
            wdata_q <= 8'h00;
        end
        else if (go && st_q == ssr_pkg::HS_IDLE)
        begin
            req_q   <= 1'b1;
            we_q    <= PWDATA[ssr_pkg::CMD_WRITE_BIT];
            addr_q  <= PWDATA[7:0];
            wdata_q <= PWDATA[ssr_pkg::CMD_WDATA_LSB +: 8];
        end
        else if (done)
            req_q <= 1'b0;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            res_q <= 16'h0000;
        else if (done)
            res_q <= LINK.rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status (write one to clear, a new event wins) and mask
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            istat_q <= '0;
        else
        begin
            for (int i = 0; i < ssr_pkg::IRQ_W; i++)
            begin
                if ((i == ssr_pkg::IRQ_DONE_BIT && done)
                    || (i == ssr_pkg::IRQ_REF_BIT && go
                        && st_q != ssr_pkg::HS_IDLE))
                    istat_q[i] <= 1'b1;
                else if (apb_wr && PADDR == ssr_pkg::H_ISTAT && PWDATA[i])
                    istat_q[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            imask_q <= '0;
        else if (apb_wr && PADDR == ssr_pkg::H_IMASK)
            imask_q <= PWDATA[ssr_pkg::IRQ_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data captured in the setup cycle
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            prdata_q <= 32'h0000_0000;
        else if (PSEL && !PENABLE)
        begin
            prdata_q <= 32'h0000_0000;
            if (PADDR == ssr_pkg::H_CMD)
                prdata_q <= {15'h0000, we_q, wdata_q, addr_q};
            else if (PADDR == ssr_pkg::H_RESULT)
                prdata_q <= {15'h0000, st_q != ssr_pkg::HS_IDLE, res_q};
            else if (PADDR == ssr_pkg::H_ISTAT)
                prdata_q <= {30'h0000_0000, istat_q};
            else if (PADDR == ssr_pkg::H_IMASK)
                prdata_q <= {30'h0000_0000, imask_q};
        end
    end

    assign LINK.req   = req_q;
    assign LINK.we    = we_q;
    assign LINK.addr  = addr_q;
    assign LINK.wdata = wdata_q;

endmodule

//--- rtl/ssr_link_if.sv
`timescale 1ns/1ps
interface ssr_link_if;
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [15:0] rdata;
    logic        ack;

    modport dev (input req, we, addr, wdata, output rdata, ack);
    modport host (output req, we, addr, wdata, input rdata, ack);
endinterface

//--- rtl/ssr_pkg.sv
package ssr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    // Output period at the fastest output rate, in ns
    localparam int unsigned OUT_PERIOD_NS = 125_000;
    localparam int unsigned OUT_PERIOD_CYC = OUT_PERIOD_NS / CLK_PERIOD_NS;
    // Time the reset-in-progress flag stays up after reset release, in ns
    localparam int unsigned RESET_BUSY_NS  = 1_000;
    localparam int unsigned RESET_BUSY_CYC =
        (RESET_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Device register map (link addresses)
    localparam logic [7:0] ADDR_DATA_LAST = 8'h06;
    localparam logic [7:0] ADDR_SNAPSHOT  = 8'h07;
    localparam logic [7:0] ADDR_CONFIG    = 8'h08;
    localparam logic [7:0] ADDR_PSTATUS   = 8'h09;
    localparam logic [7:0] ADDR_KEY       = 8'h0a;
    localparam logic [7:0] ADDR_STROBES   = 8'h0b;
    localparam logic [7:0] ADDR_SSTATUS   = 8'h0f;

    // Primary status fields
    localparam int unsigned PS_RESET_BIT = 0;
    localparam int unsigned PS_CHK_BIT   = 1;
    localparam int unsigned PS_PROT_BIT  = 2;
    // Strobe fields
    localparam int unsigned ST_ALIGN_BIT = 0;
    localparam int unsigned ST_LATCH_BIT = 1;
    // Secondary status fields
    localparam int unsigned SS_UNREAD_BIT = 3;

    localparam logic [7:0] KEY_LOCK   = 8'hca;
    localparam logic [7:0] KEY_UNLOCK = 8'h9c;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    // Silicon revision; value is arbitrary
    localparam logic [2:0] REVISION   = 3'h5;

    ////////////////////////////////////////////////////////////////////////
    // Host controller APB map
    localparam logic [11:0] H_CMD    = 12'h000;
    localparam logic [11:0] H_RESULT = 12'h004;
    localparam logic [11:0] H_ISTAT  = 12'h008;
    localparam logic [11:0] H_IMASK  = 12'h00c;
    // Command and result fields
    localparam int unsigned CMD_WDATA_LSB = 8;
    localparam int unsigned CMD_WRITE_BIT = 16;
    localparam int unsigned CMD_GO_BIT    = 17;
    localparam int unsigned RES_BUSY_BIT  = 16;
    // Interrupt status fields
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_REF_BIT  = 1;
    localparam int unsigned IRQ_W        = 2;

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_WAIT,
        HS_DONE
    } ssr_host_state_e;

endpackage

//--- sim/ssr_link_monitor.sv
`timescale 1ns/1ps
module ssr_link_monitor (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // Link signals
    input wire logic        req,
    input wire logic        we,
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic [15:0] rdata,
    input wire logic        ack
);
    logic       take;
    logic       wr_ok;
    logic [5:0] age_q;
    logic       prot_q;
    logic [7:0] cfg_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    assign take  = req && !ack;
    // Writes count only once the reset-busy time is long over
    assign wr_ok = take && we && age_q == 6'h3f;

    ////////////////////////////////////////
    // Cycles since reset release, saturating
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            age_q <= 6'h00;
        else if (age_q != 6'h3f)
            age_q <= age_q + 6'h01;
    end

    // Expected protection state
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            prot_q <= 1'b0;
        else if (wr_ok && addr == ssr_pkg::ADDR_KEY)
            prot_q <= wdata == ssr_pkg::KEY_LOCK ? 1'b1 :
                      wdata == ssr_pkg::KEY_UNLOCK ? 1'b0 : prot_q;
    end

    // Expected configuration byte
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            cfg_q <= ssr_pkg::CONFIG_RST;
        else if (wr_ok && addr == ssr_pkg::ADDR_CONFIG && !prot_q)
            cfg_q <= wdata;
    end

    ////////////////////////////////////////
    sequence read_of(logic [7:0] a);
        take && !we && addr == a;
    endsequence

    sequence ss_read_done;
        read_of(ssr_pkg::ADDR_SSTATUS) ##1 ack;
    endsequence

    chk_take_then_ack: assert property (take |=> ack ##1 !ack)
        else $error("link ack is not one pulse after a take");
    chk_reset_flag_on: assert property (
        (age_q < 6'h0a) ##0 read_of(ssr_pkg::ADDR_PSTATUS) |=> rdata[0])
        else $error("reset flag low while reset busy");
    chk_reset_flag_off: assert property (
        (age_q == 6'h3f) ##0 read_of(ssr_pkg::ADDR_PSTATUS) |=> !rdata[0])
        else $error("reset flag high after reset time");
    chk_prot_flag: assert property (
        read_of(ssr_pkg::ADDR_PSTATUS) |=> rdata[2] == prot_q)
        else $error("protected flag disagrees with keys written");
    chk_pstat_upper_zero: assert property (
        read_of(ssr_pkg::ADDR_PSTATUS) |=> rdata[7:3] == 5'h00)
        else $error("primary status upper bits not zero");
    chk_key_reads_zero: assert property (
        read_of(ssr_pkg::ADDR_KEY) |=> ack && rdata == 16'h0000)
        else $error("key register read not zero");
    chk_cfg_guarded: assert property (
        read_of(ssr_pkg::ADDR_CONFIG) |=> rdata[7:0] == cfg_q)
        else $error("configuration byte wrong for protection state");
    chk_rev_field: assert property (
        read_of(ssr_pkg::ADDR_SSTATUS) |=> rdata[2:0] == ssr_pkg::REVISION)
        else $error("revision field wrong");
    chk_unread_clear: assert property (
        ss_read_done ##[2:40] read_of(ssr_pkg::ADDR_SSTATUS) |=> !rdata[3])
        else $error("unread flag not cleared by status read");
endmodule

//--- sim/status_lock_sync_regs_test.sv
`timescale 1ns/1ps
module status_lock_sync_regs_test;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [7:0]  cfg;
    logic        prot;
    logic        busy;
    logic        tick;
    logic        sync_p;
    logic        snap_p;
    logic [31:0] q;
    logic        err;
    logic [15:0] rd;
    int          n_fail = 0;
    int          checked = 0;
    int          cyc = 0;
    int          n_sync = 0;
    int          n_snap = 0;
    int          t_sync = 0;
    int          t_snap = 0;
    int          t_tick = 0;

    ssr_link_if link ();
    ssr_device ssr_device_i (
        .CLK(clk), .RST(rst), .LINK(link.dev), .CONFIG(cfg),
        .PROTECTED(prot), .RESET_BUSY(busy), .SAMPLE_TICK(tick),
        .SYNC_PULSE(sync_p), .SNAP_PULSE(snap_p)
    );
    ssr_host ssr_host_i (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .IRQ(irq), .LINK(link.host)
    );
    ssr_link_monitor ssr_link_monitor_i (
        .CLK(clk), .RST(rst), .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .ack(link.ack)
    );

    always #25 clk = ~clk;

    // Pulse counts and the cycle of each pulse's latest appearance
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        n_sync <= n_sync + (sync_p === 1'b1);
        n_snap <= n_snap + (snap_p === 1'b1);
        t_sync <= sync_p === 1'b1 ? cyc : t_sync;
        t_snap <= snap_p === 1'b1 ? cyc : t_snap;
        t_tick <= tick === 1'b1 ? cyc : t_tick;
    end

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        chk("apb ready", 32'h1, pready);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // One device access through the controller, polled until not busy
    task automatic dev(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        apb(1'b1, ssr_pkg::H_CMD, {14'h0000, 1'b1, wr, d, a});
        n = 0;
        do
        begin
            apb(1'b0, ssr_pkg::H_RESULT, 32'h0);
            n++;
        end
        while (q[ssr_pkg::RES_BUSY_BIT] !== 1'b0 && n < 20);
        chk("link done", 32'h0, q[ssr_pkg::RES_BUSY_BIT]);
        rd = q[15:0];
    endtask

    task automatic wait_tick();
        int t0;
        int n;
        t0 = t_tick;
        n = 0;
        while (t_tick == t0 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        chk("tick seen", 32'h1, t_tick != t0);
    endtask

    ////////////////////////////////////////
    task automatic run_reset();
        dev(1'b0, ssr_pkg::ADDR_PSTATUS, 8'h00);
        chk("reset flag early", 32'h1, rd[0]);
        repeat (60) @(posedge clk);
        chk("reset busy output", 32'h0, busy);
        dev(1'b0, ssr_pkg::ADDR_PSTATUS, 8'h00);
        chk("primary status idle", 32'h0, rd);
    endtask

    task automatic run_lock();
        dev(1'b1, ssr_pkg::ADDR_CONFIG, 8'h01);
        dev(1'b0, ssr_pkg::ADDR_PSTATUS, 8'h00);
        chk("checksum changed", 32'h2, rd);
        dev(1'b1, ssr_pkg::ADDR_KEY, ssr_pkg::KEY_LOCK);
        dev(1'b0, ssr_pkg::ADDR_PSTATUS, 8'h00);
        chk("protected status", 32'h4, rd);
        chk("protected output", 32'h1, prot);
        dev(1'b0, ssr_pkg::ADDR_KEY, 8'h00);
        chk("key readback", 32'h0, rd);
        dev(1'b1, ssr_pkg::ADDR_CONFIG, 8'ha5);
        dev(1'b1, ssr_pkg::ADDR_KEY, 8'h11);
        dev(1'b0, ssr_pkg::ADDR_CONFIG, 8'h00);
        chk("locked config", 32'h1, rd);
        chk("still protected", 32'h1, prot);
        dev(1'b1, ssr_pkg::ADDR_KEY, ssr_pkg::KEY_UNLOCK);
        dev(1'b0, ssr_pkg::ADDR_PSTATUS, 8'h00);
        chk("released status", 32'h0, rd);
        dev(1'b1, ssr_pkg::ADDR_CONFIG, 8'ha5);
        chk("config output", 32'ha5, cfg);
    endtask

    task automatic run_strobe();
        int s;
        int d;
        dev(1'b1, ssr_pkg::ADDR_STROBES, 8'h01);
        chk("align pulses", 32'h1, n_sync);
        chk("no latch on align", 32'h0, n_snap);
        repeat (100) @(posedge clk);
        dev(1'b1, ssr_pkg::ADDR_STROBES, 8'h02);
        chk("latch pulses", 32'h1, n_snap);
        dev(1'b0, ssr_pkg::ADDR_SNAPSHOT, 8'h00);
        chk("snapshot upper", 32'h0, rd[15:12]);
        s = rd[11:0];
        d = t_snap - t_sync;
        chk("snapshot count", 32'h1, s >= d - 2 && s <= d);
        wait_tick();
        d = t_tick - t_sync;
        chk("align to tick", 32'h1, d >= 2499 && d <= 2501);
    endtask

    task automatic run_unread();
        dev(1'b0, ssr_pkg::ADDR_SSTATUS, 8'h00);
        chk("revision", ssr_pkg::REVISION, rd[2:0]);
        dev(1'b0, ssr_pkg::ADDR_DATA_LAST, 8'h00);
        wait_tick();
        dev(1'b0, ssr_pkg::ADDR_SSTATUS, 8'h00);
        dev(1'b0, ssr_pkg::ADDR_DATA_LAST, 8'h00);
        wait_tick();
        dev(1'b0, ssr_pkg::ADDR_SSTATUS, 8'h00);
        chk("unread after access", 32'h0, rd[3]);
        wait_tick();
        dev(1'b0, ssr_pkg::ADDR_SSTATUS, 8'h00);
        chk("unread after miss", 32'h1, rd[3]);
        dev(1'b0, ssr_pkg::ADDR_SSTATUS, 8'h00);
        chk("unread cleared", 32'h0, rd[3]);
    endtask

    task automatic run_irq();
        apb(1'b1, ssr_pkg::H_IMASK, 32'h0);
        apb(1'b1, ssr_pkg::H_ISTAT, 32'h3);
        dev(1'b0, ssr_pkg::ADDR_CONFIG, 8'h00);
        apb(1'b0, ssr_pkg::H_ISTAT, 32'h0);
        chk("done status", 32'h1, q);
        @(negedge clk);
        chk("irq masked", 32'h0, irq);
        apb(1'b1, ssr_pkg::H_IMASK, 32'h1);
        @(negedge clk);
        chk("irq raised", 32'h1, irq);
        apb(1'b1, ssr_pkg::H_ISTAT, 32'h1);
        @(negedge clk);
        chk("irq cleared", 32'h0, irq);
        // Second command lands while the first is still finishing
        apb(1'b1, ssr_pkg::H_CMD,
            {14'h0000, 1'b1, 1'b0, 8'h00, ssr_pkg::ADDR_SSTATUS});
        apb(1'b1, ssr_pkg::H_CMD,
            {14'h0000, 1'b1, 1'b0, 8'h00, ssr_pkg::ADDR_CONFIG});
        apb(1'b0, ssr_pkg::H_ISTAT, 32'h0);
        chk("refused status", 32'h3, q);
        apb(1'b0, ssr_pkg::H_RESULT, 32'h0);
        chk("refused ignored", {29'h0, ssr_pkg::REVISION}, q);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped error", 32'h1, err);
        chk("unmapped data", 32'h0, q);
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        chk("busy in reset", 32'h1, busy);
        rst <= 1'b0;
        run_reset();
        run_lock();
        run_strobe();
        run_unread();
        run_irq();
        print_verdict();
    end

    // Run needs about 10300 cycles
    initial
    begin
        repeat (30000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule
